/* verilog/pmtbc_core.sv */
// Behaviour
// - bit 15 enables the module; external sync edges still set the sync status bit while it is clear
// - bit 13 halts time base in idle
// - bit 12 reads special event pending
// - bit 11 gates special event interrupt
// - bit 10 set: period loads immediately
// - bit 9 inverts sync in and out
// - bit 8 enables sync output pin
// - bit 7 lets external sync restart counter
// - divider codes 000..110 give 1..64
// - divider resets to divide-by-1
// - divider bits 15..3 read zero
//
// The register offsets and the address-and-strobe port are this design's own decisions.
`timescale 1ns/1ps
`include "pmtbc_map.svh"
module pmtbc_core
    import pmtbc_pkg::*;
#(
    parameter int WIDTH = 16
)
(
    input  wire logic             clk,         // 20 MHz clock
    input  wire logic             rst_b,       // Async reset
    input  wire logic [3:0]       addr,        // Register index
    input  wire logic [WIDTH-1:0] wdata,       // Write data
    input  wire logic             wr,          // Write strobe
    input  wire logic             rd,          // Read strobe
    output logic      [WIDTH-1:0] rdata,       // Read data
    input  wire logic             cpu_idle,    // Processor idle
    input  wire logic             special_evt, // Special event pulse
    input  wire logic [1:0]       sync_in_pin, // Sync inputs
    output logic                  sync_out_pin,// Sync output
    output logic                  sync_out_oe, // Sync output enable
    output logic                  irq,         // Interrupt level
    output logic                  special_irq  // Special event request
);
    logic [WIDTH-1:0] ctrl_q;
    logic [2:0]       div_q;
    logic [WIDTH-1:0] per_buf_q;
    logic [WIDTH-1:0] per_act_q;
    logic             per_pend_q;
    logic [WIDTH-1:0] cnt_q;
    logic [5:0]       pre_q;
    logic [2:0]       stat_q;
    logic [2:0]       mask_q;
    logic             sepend_q;
    logic [1:0]       s1_q;
    logic [1:0]       s2_q;
    logic             s3_q;
    logic             idle1_q;
    logic             idle2_q;
    logic [2:0]       stat_set;
    pmtbc_state_type  st_q;

    logic on;
    logic sync_lvl;
    logic sync_edge;
    logic tick;
    logic wrap;
    logic [5:0] pre_max;
    logic wr_ctrl;
    logic wr_per;

    assign on      = ctrl_q[`PMTBC_ON_BIT];
    assign wr_ctrl = wr && (addr == `PMTBC_CTRL_IDX);
    assign wr_per  = wr && (addr == `PMTBC_PERIOD_IDX);

    // Input synchronisers
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            s1_q    <= 2'h0;
            s2_q    <= 2'h0;
            idle1_q <= 1'b0;
            idle2_q <= 1'b0;
        end
        else
        begin
            s1_q    <= sync_in_pin;
            s2_q    <= s1_q;
            idle1_q <= cpu_idle;
            idle2_q <= idle1_q;
        end
    end

    // Source select and polarity
    always_comb
    begin
        case (ctrl_q[`PMTBC_SRC_HI:`PMTBC_SRC_LO])
            3'h0:    sync_lvl = s2_q[0];
            3'h1:    sync_lvl = s2_q[1];
            default: sync_lvl = 1'b0;
        endcase
        sync_lvl = sync_lvl ^ ctrl_q[`PMTBC_INV_BIT];
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            s3_q <= 1'b0;
        else
            s3_q <= sync_lvl;
    end

    assign sync_edge = sync_lvl && !s3_q && ctrl_q[`PMTBC_EXT_SYNC_EN_BIT];

    // Run state
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            st_q <= PMTBC_OFF;
        else
        begin
            case (st_q)
                PMTBC_OFF:
                    if (on)
                        st_q <= PMTBC_RUN;
                PMTBC_RUN:
                    if (!on)
                        st_q <= PMTBC_OFF;
                    else if (idle2_q && ctrl_q[`PMTBC_IDLE_BIT])
                        st_q <= PMTBC_HALT;
                PMTBC_HALT:
                    if (!on)
                        st_q <= PMTBC_OFF;
                    else if (!(idle2_q && ctrl_q[`PMTBC_IDLE_BIT]))
                        st_q <= PMTBC_RUN;
                default:
                    st_q <= PMTBC_OFF;
            endcase
        end
    end

    // Prescaler: divide by 2^code
    assign pre_max = 6'((7'h1 << div_q) - 7'h1);
    assign tick    = (st_q == PMTBC_RUN) && (pre_q >= pre_max);
    assign wrap    = tick && (cnt_q >= per_act_q);

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            pre_q <= 6'h0;
        else if (st_q != PMTBC_RUN || tick || sync_edge)
            pre_q <= 6'h0;
        else
            pre_q <= pre_q + 6'h1;
    end

    // Master counter
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            cnt_q <= '0;
        else if (st_q == PMTBC_OFF)
            cnt_q <= '0;
        else if (sync_edge && st_q == PMTBC_RUN)
            cnt_q <= '0;
        else if (wrap)
            cnt_q <= '0;
        else if (tick)
            cnt_q <= cnt_q + 1'b1;
    end

    // Period registers
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            per_buf_q  <= `PMTBC_PERIOD_RST;
            per_act_q  <= `PMTBC_PERIOD_RST;
            per_pend_q <= 1'b0;
        end
        else if (wr_per)
        begin
            per_buf_q <= wdata;
            if (ctrl_q[`PMTBC_IMM_BIT] || !on)
            begin
                per_act_q  <= wdata;
                per_pend_q <= 1'b0;
            end
            else
                per_pend_q <= 1'b1;
        end
        else if (per_pend_q && (wrap || sync_edge))
        begin
            per_act_q  <= per_buf_q;
            per_pend_q <= 1'b0;
        end
    end

    // Control and divider registers
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            ctrl_q <= `PMTBC_CTRL_RST;
            div_q  <= `PMTBC_CLKDIV_RST;
        end
        else if (wr_ctrl)
            ctrl_q <= wdata & `PMTBC_CTRL_WMASK;
        else if (wr && addr == `PMTBC_CLKDIV_IDX
                 && wdata[2:0] <= `PMTBC_DIV_MAX)
            div_q <= wdata[2:0];
    end

    // Special event pending, set wins over clear
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            sepend_q <= 1'b0;
        else if (special_evt && on)
            sepend_q <= 1'b1;
        else if (wr_ctrl && !wdata[`PMTBC_SEPEND_BIT])
            sepend_q <= 1'b0;
    end

    // Interrupt mask
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            mask_q <= 3'h0;
        else if (wr && addr == `PMTBC_IRQ_MASK_IDX)
            mask_q <= wdata[2:0];
    end

    // Interrupt status, write one to clear, set wins
    assign stat_set[`PMTBC_EV_SPECIAL] = special_evt && on;
    assign stat_set[`PMTBC_EV_PERIOD]  = wrap;
    assign stat_set[`PMTBC_EV_SYNC]    = sync_edge;
    for (genvar g = 0; g < 3; g++)
    begin : g_stat
        always_ff @(posedge clk or negedge rst_b)
        begin
            if (!rst_b)
                stat_q[g] <= 1'b0;
            else if (stat_set[g])
                stat_q[g] <= 1'b1;
            else if (wr && addr == `PMTBC_IRQ_STAT_IDX && wdata[g])
                stat_q[g] <= 1'b0;
        end
    end

    // Outputs
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            irq          <= 1'b0;
            special_irq  <= 1'b0;
            sync_out_pin <= 1'b0;
            sync_out_oe  <= 1'b0;
        end
        else
        begin
            irq          <= |(stat_q & mask_q);
            special_irq  <= sepend_q && ctrl_q[`PMTBC_SPECIAL_EVENT_IRQ_EN_BIT];
            sync_out_oe  <= ctrl_q[`PMTBC_SOE_BIT] && on;
            sync_out_pin <= ctrl_q[`PMTBC_SOE_BIT] && on
                            && (wrap ^ ctrl_q[`PMTBC_INV_BIT]);
        end
    end

    // Read port
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            rdata <= '0;
        else if (rd)
        begin
            case (addr)
                `PMTBC_CTRL_IDX:
                begin
                    rdata <= ctrl_q;
                    rdata[`PMTBC_SEPEND_BIT] <= sepend_q;
                end
                `PMTBC_CLKDIV_IDX:   rdata <= {13'h0, div_q};
                `PMTBC_PERIOD_IDX:   rdata <= per_buf_q;
                `PMTBC_IRQ_STAT_IDX: rdata <= {13'h0, stat_q};
                `PMTBC_IRQ_MASK_IDX: rdata <= {13'h0, mask_q};
                `PMTBC_COUNT_IDX:    rdata <= cnt_q;
                default:             rdata <= '0;
            endcase
        end
        else
            rdata <= '0;
    end

    // Assertions
    off_clears_cnt_a: assert property (
        @(posedge clk) disable iff (!rst_b)
        st_q == PMTBC_OFF |=> cnt_q == '0)
        else $error("counter not held while disabled");
    idle_halt_a: assert property (
        @(posedge clk) disable iff (!rst_b)
        st_q == PMTBC_HALT |=> $stable(cnt_q))
        else $error("counter moved while halted");
    pend_read_a: assert property (
        @(posedge clk) disable iff (!rst_b)
        rd && addr == `PMTBC_CTRL_IDX |=> rdata[12] == $past(sepend_q))
        else $error("pending bit read wrong");
    pend_set_a: assert property (
        @(posedge clk) disable iff (!rst_b)
        special_evt && on |=> sepend_q)
        else $error("pending bit not set by event");
    irq_gate_a: assert property (
        @(posedge clk) disable iff (!rst_b)
        special_irq |-> $past(ctrl_q[11]))
        else $error("special irq while disabled");
    irq_raise_a: assert property (
        @(posedge clk) disable iff (!rst_b)
        sepend_q && ctrl_q[11] |=> special_irq)
        else $error("special irq not raised");
    imm_load_a: assert property (
        @(posedge clk) disable iff (!rst_b)
        wr_per && ctrl_q[10] |=> per_act_q == $past(wdata))
        else $error("immediate period load missing");
    defer_load_a: assert property (
        @(posedge clk) disable iff (!rst_b)
        on && !wr_per && !wrap && !sync_edge |=> $stable(per_act_q))
        else $error("period changed off boundary");
    sync_out_a: assert property (
        @(posedge clk) disable iff (!rst_b)
        wrap && ctrl_q[8] && on |=> sync_out_pin != $past(ctrl_q[9]))
        else $error("sync output pulse wrong");
    sync_oe_a: assert property (
        @(posedge clk) disable iff (!rst_b)
        !ctrl_q[8] |=> !sync_out_oe)
        else $error("sync output enabled while off");
    sync_restart_a: assert property (
        @(posedge clk) disable iff (!rst_b)
        sync_edge && st_q == PMTBC_RUN |=> cnt_q == '0)
        else $error("sync did not restart counter");
    sync_src_a: assert property (
        @(posedge clk) disable iff (!rst_b)
        ctrl_q[6:5] != 2'h0 |-> !sync_edge)
        else $error("reserved source produced sync");
    div_range_a: assert property (
        @(posedge clk) disable iff (!rst_b)
        div_q <= `PMTBC_DIV_MAX)
        else $error("divider code reserved");
    div_read_a: assert property (
        @(posedge clk) disable iff (!rst_b)
        rd |=> rdata[15:3] == '0 || $past(addr) != `PMTBC_CLKDIV_IDX)
        else $error("divider upper bits nonzero");
    defer_c: cover property (@(posedge clk) disable iff (!rst_b)
        per_pend_q && wrap);
    wrap_c: cover property (@(posedge clk) disable iff (!rst_b) wrap);
    sync_c: cover property (@(posedge clk) disable iff (!rst_b) sync_edge);
    halt_c: cover property (@(posedge clk) disable iff (!rst_b)
        st_q == PMTBC_HALT);
    irq_c: cover property (@(posedge clk) disable iff (!rst_b) irq);
endmodule : pmtbc_core

/* verilog/pmtbc_map.svh */
`ifndef PMTBC_MAP_SVH
`define PMTBC_MAP_SVH
// Register indices; byte address is four times the index
`define PMTBC_CTRL_IDX      4'h0
`define PMTBC_CLKDIV_IDX    4'h1
`define PMTBC_PERIOD_IDX    4'h2
`define PMTBC_IRQ_STAT_IDX  4'h3
`define PMTBC_IRQ_MASK_IDX  4'h4
`define PMTBC_COUNT_IDX     4'h5
// Control field positions
`define PMTBC_ON_BIT        15
`define PMTBC_IDLE_BIT      13
`define PMTBC_SEPEND_BIT    12
`define PMTBC_SPECIAL_EVENT_IRQ_EN_BIT     11
`define PMTBC_IMM_BIT       10
`define PMTBC_INV_BIT       9
`define PMTBC_SOE_BIT       8
`define PMTBC_EXT_SYNC_EN_BIT    7
`define PMTBC_SRC_HI        6
`define PMTBC_SRC_LO        4
`define PMTBC_SEPS_HI       3
`define PMTBC_SEPS_LO       0
// Writable control bits (pending bit is hardware owned)
`define PMTBC_CTRL_WMASK    16'hAFFF
// Reset values and divider code limit
`define PMTBC_CTRL_RST      16'h0000
`define PMTBC_CLKDIV_RST    3'h0
`define PMTBC_PERIOD_RST    16'hFFF8
`define PMTBC_DIV_MAX       3'h6
// Interrupt status bits
`define PMTBC_EV_SPECIAL    0
`define PMTBC_EV_PERIOD     1
`define PMTBC_EV_SYNC       2
`endif

/* verilog/pmtbc_pkg.sv */
package pmtbc_pkg;
    typedef enum logic [1:0]
    {
        PMTBC_OFF  = 2'b00,
        PMTBC_RUN  = 2'b01,
        PMTBC_HALT = 2'b11
    } pmtbc_state_type;
endpackage : pmtbc_pkg

/* bench/pmtbc_sync_partner.sv */
`timescale 1ns/1ps
module pmtbc_sync_partner
(
    input  wire logic        clk,          // Clock
    input  wire logic        rst_b,        // Async reset
    input  wire logic        sync_out_pin, // Sync out of block
    input  wire logic        sync_out_oe,  // Its enable
    input  wire logic        inv,          // Pin polarity
    input  wire logic [1:0]  fire,         // Pulse request
    output logic      [1:0]  sync_in_pin,  // Sync into block
    output logic      [7:0]  pulses,       // Pulses seen
    output logic      [15:0] gap           // Last pulse spacing
);
    logic [15:0] cnt_q;
    // Idle level follows polarity
    assign sync_in_pin = {2{inv}} ^ fire;
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            cnt_q  <= 16'h0000;
            pulses <= 8'h00;
            gap    <= 16'h0000;
        end
        else if (sync_out_oe && (sync_out_pin ^ inv))
        begin
            cnt_q  <= 16'h0000;
            pulses <= pulses + 8'h01;
            gap    <= cnt_q + 16'h0001;
        end
        else
        begin
            cnt_q <= cnt_q + 16'h0001;
        end
    end
endmodule : pmtbc_sync_partner

/* bench/pmtbc_core_test.sv */
`timescale 1ns/1ps
`include "pmtbc_map.svh"
module pmtbc_core_test;
    localparam logic [3:0] CTL = `PMTBC_CTRL_IDX;
    localparam logic [3:0] DIV = `PMTBC_CLKDIV_IDX;
    localparam logic [3:0] PER = `PMTBC_PERIOD_IDX;
    localparam logic [3:0] STA = `PMTBC_IRQ_STAT_IDX;
    localparam logic [3:0] MSK = `PMTBC_IRQ_MASK_IDX;
    localparam logic [3:0] CNT = `PMTBC_COUNT_IDX;
    logic        clk, rst_b, wr, rd, cpu_idle, special_evt, inv;
    logic        sync_out_pin, sync_out_oe, irq, special_irq;
    logic [3:0]  addr;
    logic [1:0]  sync_in_pin, fire;
    logic [7:0]  pulses;
    logic [15:0] wdata, rdata, a, b, k, gap;
    int          failures, compares, i;
    int          cycles = 0;
    logic [15:0] cfg [6] = '{16'h8090, 16'h8090, 16'h8080, 16'h8010,
                             16'h8290, 16'h80A0};
    logic [1:0]  pin [6] = '{2'b10, 2'b01, 2'b01, 2'b10, 2'b10, 2'b11};
    logic [15:0] hit [6] = '{16'h0004, 16'h0000, 16'h0004, 16'h0000,
                             16'h0004, 16'h0000};

    pmtbc_core i_pmtbc_core (.clk, .rst_b, .addr, .wdata, .wr, .rd,
        .rdata, .cpu_idle, .special_evt, .sync_in_pin, .sync_out_pin,
        .sync_out_oe, .irq, .special_irq);
    pmtbc_sync_partner i_pmtbc_sync_partner (.clk, .rst_b, .sync_out_pin,
        .sync_out_oe, .inv, .fire, .sync_in_pin, .pulses, .gap);

    initial
    begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    task check(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp)
        begin
            failures++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check

    task conclude;
        $display("failures=%0d compares=%0d", failures, compares);
        if (failures == 0 && compares > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : conclude

    task cyc(input int n);
        repeat (n) @(posedge clk);
    endtask : cyc

    task wreg(input logic [3:0] ad, input logic [15:0] d);
        @(posedge clk);
        addr  <= ad;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask : wreg

    task rreg(input logic [3:0] ad, output logic [15:0] d);
        @(posedge clk);
        addr <= ad;
        rd   <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 d = rdata;
    endtask : rreg

    task rchk(input logic [3:0] ad, input logic [15:0] exp);
        rreg(ad, a);
        check(a, exp);
    endtask : rchk

    // Bounded wait for the next sync output pulse
    task wait_pulse;
        logic [7:0] n;
        n = pulses;
        for (int j = 0; j < 300 && pulses === n; j++)
        begin
            @(posedge clk);
            #1;
        end
        if (pulses === n)
        begin
            failures++;
            conclude();
        end
    endtask : wait_pulse

    always @(posedge clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 20000)
        begin
            failures++;
            conclude();
        end
    end

    initial
    begin
        {rst_b, wr, rd, cpu_idle, special_evt, inv, fire} = '0;
        addr = 4'h0;
        wdata = 16'h0000;
        failures = 0;
        compares = 0;
        repeat (4) @(posedge clk);
        rst_b <= 1'b1;
        rchk(CTL, 16'h0000);
        rchk(DIV, 16'h0000);
        rchk(PER, 16'hFFF8);
        rchk(4'hF, 16'h0000);
        wreg(DIV, 16'hFFFE);
        rchk(DIV, 16'h0006);
        wreg(DIV, 16'hFFFF);
        rchk(DIV, 16'h0006);
        for (k = 0; k < 7; k++)
        begin
            wreg(CTL, 16'h0000);
            wreg(DIV, k);
            wreg(CTL, 16'h8000);
            rreg(CNT, a);
            cyc(126);
            rreg(CNT, b);
            check({15'h0, b - a + 16'h0001 - (16'h0080 >> k) <= 16'h0002},
                  16'h0001);
        end
        wreg(CTL, 16'h0000);
        wreg(DIV, 16'h0000);
        cyc(2);
        rreg(CNT, a);
        cyc(20);
        rchk(CNT, 16'h0000);
        wreg(CTL, 16'hA000);
        cpu_idle <= 1'b1;
        cyc(5);
        rreg(CNT, a);
        cyc(20);
        rchk(CNT, a);
        wreg(CTL, 16'h8000);
        cyc(3);
        rreg(CNT, b);
        check({15'h0, b != a}, 16'h0001);
        cpu_idle <= 1'b0;
        wreg(STA, 16'h0007);
        @(posedge clk) special_evt <= 1'b1;
        @(posedge clk) special_evt <= 1'b0;
        cyc(2);
        rchk(CTL, 16'h9000);
        check({15'h0, special_irq}, 16'h0000);
        wreg(CTL, 16'h9800);
        cyc(2);
        check({15'h0, special_irq}, 16'h0001);
        rreg(STA, a);
        check(a & 16'h0001, 16'h0001);
        check({15'h0, irq}, 16'h0000);
        wreg(MSK, 16'h0001);
        cyc(2);
        check({15'h0, irq}, 16'h0001);
        wreg(STA, 16'h0001);
        cyc(2);
        check({15'h0, irq}, 16'h0000);
        wreg(CTL, 16'h8800);
        cyc(2);
        rchk(CTL, 16'h8800);
        check({15'h0, special_irq}, 16'h0000);
        wreg(MSK, 16'h0000);
        // Second round uses immediate load and inverted polarity
        for (k = 0; k < 2; k++)
        begin
            wreg(CTL, 16'h0000);
            inv <= k[0];
            wreg(PER, 16'h0010);
            wreg(CTL, 16'h8100 | (k << 10) | (k << 9));
            wait_pulse();
            wreg(PER, 16'h0030);
            wait_pulse();
            check(gap, k[0] ? 16'h0031 : 16'h0011);
            wait_pulse();
            check(gap, 16'h0031);
            check({15'h0, sync_out_oe}, 16'h0001);
        end
        wreg(CTL, 16'h0000);
        wreg(CTL, 16'h8000);
        cyc(2);
        check({15'h0, sync_out_oe}, 16'h0000);
        wreg(PER, 16'h0100);
        for (i = 0; i < 6; i++)
        begin
            wreg(CTL, 16'h0000);
            inv <= cfg[i][9];
            cyc(4);
            wreg(CTL, cfg[i]);
            cyc(4);
            wreg(STA, 16'h0007);
            @(posedge clk) fire <= pin[i];
            cyc(4);
            fire <= 2'b00;
            cyc(6);
            rreg(STA, a);
            check(a & 16'h0004, hit[i]);
        end
        conclude();
    end
endmodule : pmtbc_core_test
